// file: pcrs_map.svh
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH

// Register window held by this slice
`define PCRS_ADDR_FIRST      8'h0e
`define PCRS_ADDR_LAST       8'h1d
`define PCRS_REG_COUNT       16
`define PCRS_REG_INDEX_W     4

`define PCRS_ADDR_A_REF      8'h0e
`define PCRS_ADDR_A_LOOP     8'h11
`define PCRS_ADDR_B_REF      8'h12
`define PCRS_ADDR_B_FB_HI    8'h13
`define PCRS_ADDR_B_SPR0     8'h14
`define PCRS_ADDR_B_RATE_HI  8'h15
`define PCRS_ADDR_B_CNT_HI   8'h16
`define PCRS_ADDR_B_LOW      8'h17
`define PCRS_ADDR_B_STEP_HI  8'h18
`define PCRS_ADDR_B_LOOP     8'h19
`define PCRS_ADDR_B_SPR_EN   8'h1a
`define PCRS_ADDR_C_REF      8'h1b
`define PCRS_ADDR_C_FB_HI    8'h1c
`define PCRS_ADDR_C_FB_LO    8'h1d

// Reset values
`define PCRS_RST_DEFAULT     8'h00
`define PCRS_RST_B_LOOP      8'h40

// Writable bit masks; cleared bits are reserved and read zero
`define PCRS_MASK_FULL       8'hff
`define PCRS_MASK_NONE       8'h00
`define PCRS_MASK_A_LOOP     8'h7f
`define PCRS_MASK_B_LOOP     8'h77
`define PCRS_MASK_SPR_EN     8'h08
`define PCRS_MASK_LOW3       8'h07

// Field positions
`define PCRS_A_PREDIV_BIT    6
`define PCRS_A_RZ_MSB        5
`define PCRS_A_RZ_LSB        4
`define PCRS_A_IP_MSB        3
`define PCRS_A_IP_LSB        1
`define PCRS_A_SEL_BIT       0
`define PCRS_B_IP_MSB        6
`define PCRS_B_IP_LSB        4
`define PCRS_B_SEL_BIT       2
`define PCRS_B_RZ_MSB        1
`define PCRS_B_RZ_LSB        0
`define PCRS_SPR_EN_BIT      3
`define PCRS_LOW3_MSB        2
`define PCRS_LOW3_LSB        0
`define PCRS_UP5_MSB         7
`define PCRS_UP5_LSB         3

// Decoded analog settings
`define PCRS_RATIO_1         3'h1
`define PCRS_RATIO_4         3'h4
`define PCRS_KOHM_5          7'h05
`define PCRS_KOHM_10         7'h0a
`define PCRS_KOHM_30         7'h1e
`define PCRS_KOHM_80         7'h50
`define PCRS_KOHM_NONE       7'h00
// First loop pump, tenths of a microamp
`define PCRS_A_PUMP_OFF      8'h00
`define PCRS_A_PUMP_4        8'h3f
`define PCRS_A_PUMP_5        8'h77
`define PCRS_A_PUMP_6        8'hb1
`define PCRS_A_PUMP_7        8'he3
// Second loop pump, hundredths of the printed unit
`define PCRS_B_PUMP_0        12'h025
`define PCRS_B_PUMP_1        12'h06e
`define PCRS_B_PUMP_2        12'h0b4
`define PCRS_B_PUMP_3        12'h154
`define PCRS_B_PUMP_4        12'h276
`define PCRS_B_PUMP_5        12'h4a6
`define PCRS_B_PUMP_6        12'h6ea
`define PCRS_B_PUMP_7        12'h8de

`endif

// file: pcrs_pkg.sv
package pcrs_pkg;

  typedef enum logic [1:0] {
    PCRS_RZ_5K  = 2'b00,
    PCRS_RZ_10K = 2'b01,
    PCRS_RZ_30K = 2'b10,
    PCRS_RZ_80K = 2'b11
  } pcrs_zero_res_type;

  typedef enum logic [2:0] {
    PCRS_IP_0 = 3'b000,
    PCRS_IP_1 = 3'b001,
    PCRS_IP_2 = 3'b010,
    PCRS_IP_3 = 3'b011,
    PCRS_IP_4 = 3'b100,
    PCRS_IP_5 = 3'b101,
    PCRS_IP_6 = 3'b110,
    PCRS_IP_7 = 3'b111
  } pcrs_pump_type;

endpackage

// file: pcrs_shadow_if.sv
`timescale 1ns/100ps
interface pcrs_shadow_if #(
  parameter int W = 11
);
  logic [W-1:0] stage;
  logic         load;
  logic [W-1:0] applied;

  modport src (output stage, output load, input applied);
  modport dst (input stage, input load, output applied);
endinterface

// file: pcrs_shadow.sv
`timescale 1ns/100ps
module pcrs_shadow #(
  parameter int W = 11
) (
  input wire logic    i_clk,
  input wire logic    i_rst_n,
  pcrs_shadow_if.dst  bus
);

  logic [W-1:0] applied_r;

  if (W < 1 || $bits(bus.stage) != W) begin : g_check
    $error("pcrs_shadow: width does not match its carrier");
  end

  // Whole field moves in one edge so the divider never sees a half value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      applied_r <= '0;
    end else if (bus.load) begin
      applied_r <= bus.stage;
    end
  end

  assign bus.applied = applied_r;

  property p_shadow_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !bus.load |=> $stable(bus.applied);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("applied field moved without a load");

  property p_shadow_take;
    @(posedge i_clk) disable iff (!i_rst_n)
      bus.load |=> bus.applied == $past(bus.stage);
  endproperty
  a_shadow_take: assert property (p_shadow_take)
    else $error("applied field differs from staged value");

endmodule

// file: pcrs_loop_decode.sv
`timescale 1ns/100ps
`include "pcrs_map.svh"
module pcrs_loop_decode (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_a_loop,
  input  wire logic [7:0]  i_b_loop,
  output logic      [2:0]  o_a_ratio,
  output logic      [6:0]  o_a_kohm,
  output logic      [7:0]  o_a_pump,
  output logic      [6:0]  o_b_kohm,
  output logic      [11:0] o_b_pump
);

  function automatic logic [6:0] kohm_of(input logic [1:0] code, input logic top_ok);
    logic [6:0] k;
    k = `PCRS_KOHM_NONE;
    unique case (pcrs_pkg::pcrs_zero_res_type'(code))
      pcrs_pkg::PCRS_RZ_5K:  k = `PCRS_KOHM_5;
      pcrs_pkg::PCRS_RZ_10K: k = `PCRS_KOHM_10;
      pcrs_pkg::PCRS_RZ_30K: k = `PCRS_KOHM_30;
      // Second loop has no top step; that code gives no resistance value
      pcrs_pkg::PCRS_RZ_80K: k = top_ok ? `PCRS_KOHM_80 : `PCRS_KOHM_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [7:0] a_pump_of(input logic [2:0] code);
    logic [7:0] p;
    p = `PCRS_A_PUMP_OFF;
    unique case (pcrs_pkg::pcrs_pump_type'(code))
      pcrs_pkg::PCRS_IP_4: p = `PCRS_A_PUMP_4;
      pcrs_pkg::PCRS_IP_5: p = `PCRS_A_PUMP_5;
      pcrs_pkg::PCRS_IP_6: p = `PCRS_A_PUMP_6;
      pcrs_pkg::PCRS_IP_7: p = `PCRS_A_PUMP_7;
      pcrs_pkg::PCRS_IP_0, pcrs_pkg::PCRS_IP_1,
      pcrs_pkg::PCRS_IP_2, pcrs_pkg::PCRS_IP_3: p = `PCRS_A_PUMP_OFF;
    endcase
    return p;
  endfunction

  function automatic logic [11:0] b_pump_of(input logic [2:0] code);
    logic [11:0] p;
    p = `PCRS_B_PUMP_0;
    unique case (pcrs_pkg::pcrs_pump_type'(code))
      pcrs_pkg::PCRS_IP_0: p = `PCRS_B_PUMP_0;
      pcrs_pkg::PCRS_IP_1: p = `PCRS_B_PUMP_1;
      pcrs_pkg::PCRS_IP_2: p = `PCRS_B_PUMP_2;
      pcrs_pkg::PCRS_IP_3: p = `PCRS_B_PUMP_3;
      pcrs_pkg::PCRS_IP_4: p = `PCRS_B_PUMP_4;
      pcrs_pkg::PCRS_IP_5: p = `PCRS_B_PUMP_5;
      pcrs_pkg::PCRS_IP_6: p = `PCRS_B_PUMP_6;
      pcrs_pkg::PCRS_IP_7: p = `PCRS_B_PUMP_7;
    endcase
    return p;
  endfunction

  wire [2:0]  a_ratio_nxt = i_a_loop[`PCRS_A_PREDIV_BIT] ? `PCRS_RATIO_4 : `PCRS_RATIO_1;
  wire [6:0]  a_kohm_nxt  = kohm_of(i_a_loop[`PCRS_A_RZ_MSB:`PCRS_A_RZ_LSB], 1'h1);
  wire [7:0]  a_pump_nxt  = a_pump_of(i_a_loop[`PCRS_A_IP_MSB:`PCRS_A_IP_LSB]);
  wire [6:0]  b_kohm_nxt  = kohm_of(i_b_loop[`PCRS_B_RZ_MSB:`PCRS_B_RZ_LSB], 1'h0);
  wire [11:0] b_pump_nxt  = b_pump_of(i_b_loop[`PCRS_B_IP_MSB:`PCRS_B_IP_LSB]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_a_ratio <= `PCRS_RATIO_1;
      o_a_kohm  <= `PCRS_KOHM_5;
      o_a_pump  <= `PCRS_A_PUMP_OFF;
      o_b_kohm  <= `PCRS_KOHM_5;
      o_b_pump  <= `PCRS_B_PUMP_4;
    end else begin
      o_a_ratio <= a_ratio_nxt;
      o_a_kohm  <= a_kohm_nxt;
      o_a_pump  <= a_pump_nxt;
      o_b_kohm  <= b_kohm_nxt;
      o_b_pump  <= b_pump_nxt;
    end
  end

  default clocking cb_dec @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_a_ratio;
    ##1 o_a_ratio == ($past(i_a_loop[`PCRS_A_PREDIV_BIT]) ? 3'h4 : 3'h1);
  endproperty
  a_a_ratio: assert property (p_a_ratio)
    else $error("first loop predivide ratio wrong");

  property p_a_kohm;
    i_a_loop[`PCRS_A_RZ_MSB:`PCRS_A_RZ_LSB] == pcrs_pkg::PCRS_RZ_80K |=> o_a_kohm == 7'h50;
  endproperty
  a_a_kohm: assert property (p_a_kohm)
    else $error("first loop top resistor step wrong");

  property p_a_pump;
    i_a_loop[`PCRS_A_IP_MSB:`PCRS_A_IP_LSB] == pcrs_pkg::PCRS_IP_4 |=> o_a_pump == 8'h3f;
  endproperty
  a_a_pump: assert property (p_a_pump)
    else $error("first loop lowest pump step wrong");

  property p_b_kohm;
    i_b_loop[`PCRS_B_RZ_MSB:`PCRS_B_RZ_LSB] == pcrs_pkg::PCRS_RZ_30K |=> o_b_kohm == 7'h1e;
  endproperty
  a_b_kohm: assert property (p_b_kohm)
    else $error("second loop resistor step wrong");

  property p_b_pump;
    i_b_loop[`PCRS_B_IP_MSB:`PCRS_B_IP_LSB] == pcrs_pkg::PCRS_IP_7 |=> o_b_pump == 12'h8de;
  endproperty
  a_b_pump: assert property (p_b_pump)
    else $error("second loop top pump step wrong");

endmodule

// file: pcrs_top.sv
`timescale 1ns/100ps
`include "pcrs_map.svh"
module pcrs_top (
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WE,
  input  wire logic        I_RE,
  output logic      [7:0]  O_RDATA,
  output logic      [7:0]  O_PLL_A_REFERENCE_DIVIDER,
  output logic             O_PLL_A_FEEDBACK_PREDIVIDE,
  output logic      [2:0]  O_PLL_A_PREDIVIDE_RATIO,
  output logic      [6:0]  O_PLL_A_ZERO_RESISTOR_KOHM,
  output logic      [7:0]  O_PLL_A_PUMP_CURRENT,
  output logic             O_PLL_A_INPUT_SELECT,
  output logic      [7:0]  O_PLL_B_REFERENCE_DIVIDER,
  output logic      [10:0] O_PLL_B_FEEDBACK_DIVIDER,
  output logic      [12:0] O_SPREAD_RATE_PARAM,
  output logic      [10:0] O_SPREAD_COUNT_PARAM,
  output logic      [12:0] O_SPREAD_STEP_PARAM,
  output logic      [6:0]  O_PLL_B_ZERO_RESISTOR_KOHM,
  output logic      [11:0] O_PLL_B_PUMP_CURRENT,
  output logic             O_PLL_B_INPUT_SELECT,
  output logic             O_PLL_B_SPREAD_ENABLE,
  output logic      [7:0]  O_PLL_C_REFERENCE_DIVIDER,
  output logic      [10:0] O_PLL_C_FEEDBACK_DIVIDER
);

  localparam int FB_W   = 11;
  localparam int RATE_W = 13;
  localparam int CNT_W  = 11;
  localparam int STEP_W = 13;

  // Reset release, two stages
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_r <= 1'h0;
      rst_n      <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_n      <= rst_meta_r;
    end
  end

  // Holes in the window (feedback of the first loop) have no storage
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    logic [7:0] m;
    m = `PCRS_MASK_NONE;
    case (a)
      `PCRS_ADDR_A_REF, `PCRS_ADDR_B_REF, `PCRS_ADDR_B_FB_HI,
      `PCRS_ADDR_B_SPR0, `PCRS_ADDR_B_RATE_HI, `PCRS_ADDR_B_CNT_HI,
      `PCRS_ADDR_B_LOW, `PCRS_ADDR_B_STEP_HI, `PCRS_ADDR_C_REF,
      `PCRS_ADDR_C_FB_HI: m = `PCRS_MASK_FULL;
      `PCRS_ADDR_A_LOOP:  m = `PCRS_MASK_A_LOOP;
      `PCRS_ADDR_B_LOOP:  m = `PCRS_MASK_B_LOOP;
      `PCRS_ADDR_B_SPR_EN: m = `PCRS_MASK_SPR_EN;
      `PCRS_ADDR_C_FB_LO: m = `PCRS_MASK_LOW3;
      default:            m = `PCRS_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] reset_of(input logic [7:0] a);
    return (a == `PCRS_ADDR_B_LOOP) ? `PCRS_RST_B_LOOP : `PCRS_RST_DEFAULT;
  endfunction

  logic [7:0]                 regs_r [`PCRS_REG_COUNT];
  logic [`PCRS_REG_COUNT-1:0] wr_hit;

  for (genvar g = 0; g < `PCRS_REG_COUNT; g++) begin : g_reg
    localparam logic [7:0] ADDR = `PCRS_ADDR_FIRST + 8'(g);
    localparam logic [7:0] MASK = mask_of(ADDR);
    localparam logic [7:0] RSTV = reset_of(ADDR);

    assign wr_hit[g] = I_WE && (I_ADDR == ADDR);

    always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
        regs_r[g] <= RSTV;
      end else if (wr_hit[g]) begin
        regs_r[g] <= I_WDATA & MASK;
      end
    end
  end

  wire [7:0] r_a_ref     = regs_r[4'(`PCRS_ADDR_A_REF     - `PCRS_ADDR_FIRST)];
  wire [7:0] r_a_loop    = regs_r[4'(`PCRS_ADDR_A_LOOP    - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_ref     = regs_r[4'(`PCRS_ADDR_B_REF     - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_fb_hi   = regs_r[4'(`PCRS_ADDR_B_FB_HI   - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_spr0    = regs_r[4'(`PCRS_ADDR_B_SPR0    - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_rate_hi = regs_r[4'(`PCRS_ADDR_B_RATE_HI - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_cnt_hi  = regs_r[4'(`PCRS_ADDR_B_CNT_HI  - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_low     = regs_r[4'(`PCRS_ADDR_B_LOW     - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_loop    = regs_r[4'(`PCRS_ADDR_B_LOOP    - `PCRS_ADDR_FIRST)];
  wire [7:0] r_b_spr_en  = regs_r[4'(`PCRS_ADDR_B_SPR_EN  - `PCRS_ADDR_FIRST)];
  wire [7:0] r_c_ref     = regs_r[4'(`PCRS_ADDR_C_REF     - `PCRS_ADDR_FIRST)];
  wire [7:0] r_c_fb_hi   = regs_r[4'(`PCRS_ADDR_C_FB_HI   - `PCRS_ADDR_FIRST)];

  wire w_b_spr0    = I_WE && (I_ADDR == `PCRS_ADDR_B_SPR0);
  wire w_b_step_hi = I_WE && (I_ADDR == `PCRS_ADDR_B_STEP_HI);
  wire w_c_fb_lo   = I_WE && (I_ADDR == `PCRS_ADDR_C_FB_LO);

  // Read path: one cycle after the strobe, zero outside the window
  wire                         rd_hit   = (I_ADDR >= `PCRS_ADDR_FIRST) &&
                                          (I_ADDR <= `PCRS_ADDR_LAST);
  wire [7:0]                   rd_off   = I_ADDR - `PCRS_ADDR_FIRST;
  wire [`PCRS_REG_INDEX_W-1:0] rd_index = rd_off[`PCRS_REG_INDEX_W-1:0];
  wire [7:0]                   rd_word  = rd_hit ? regs_r[rd_index] : `PCRS_RST_DEFAULT;
  logic [7:0]                  rdata_r;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `PCRS_RST_DEFAULT;
    end else if (I_RE) begin
      rdata_r <= rd_word;
    end
  end

  assign O_RDATA = rdata_r;

  // Feedback fields commit when the byte with their low bits is written, spread fields on the step high byte;
  // software must write the other bytes first or the committed value keeps their old bits
  pcrs_shadow_if #(.W(FB_W))   fb_b_if ();
  pcrs_shadow_if #(.W(RATE_W)) rate_if ();
  pcrs_shadow_if #(.W(CNT_W))  cnt_if ();
  pcrs_shadow_if #(.W(STEP_W)) step_if ();
  pcrs_shadow_if #(.W(FB_W))   fb_c_if ();

  assign fb_b_if.load  = w_b_spr0;
  assign fb_b_if.stage = {r_b_fb_hi, I_WDATA[`PCRS_LOW3_MSB:`PCRS_LOW3_LSB]};
  // Whole spread set moves together on the step high byte
  assign rate_if.load  = w_b_step_hi;
  assign rate_if.stage = {r_b_rate_hi, r_b_spr0[`PCRS_UP5_MSB:`PCRS_UP5_LSB]};
  assign cnt_if.load   = w_b_step_hi;
  assign cnt_if.stage  = {r_b_cnt_hi, r_b_low[`PCRS_LOW3_MSB:`PCRS_LOW3_LSB]};
  assign step_if.load  = w_b_step_hi;
  assign step_if.stage = {I_WDATA, r_b_low[`PCRS_UP5_MSB:`PCRS_UP5_LSB]};
  assign fb_c_if.load  = w_c_fb_lo;
  assign fb_c_if.stage = {r_c_fb_hi, I_WDATA[`PCRS_LOW3_MSB:`PCRS_LOW3_LSB]};

  pcrs_shadow #(.W(FB_W)) u_fb_b (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .bus     (fb_b_if.dst)
  );

  pcrs_shadow #(.W(RATE_W)) u_rate (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .bus     (rate_if.dst)
  );

  pcrs_shadow #(.W(CNT_W)) u_cnt (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .bus     (cnt_if.dst)
  );

  pcrs_shadow #(.W(STEP_W)) u_step (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .bus     (step_if.dst)
  );

  pcrs_shadow #(.W(FB_W)) u_fb_c (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .bus     (fb_c_if.dst)
  );

  pcrs_loop_decode u_decode (
    .i_clk     (I_CLK),
    .i_rst_n   (rst_n),
    .i_a_loop  (r_a_loop),
    .i_b_loop  (r_b_loop),
    .o_a_ratio (O_PLL_A_PREDIVIDE_RATIO),
    .o_a_kohm  (O_PLL_A_ZERO_RESISTOR_KOHM),
    .o_a_pump  (O_PLL_A_PUMP_CURRENT),
    .o_b_kohm  (O_PLL_B_ZERO_RESISTOR_KOHM),
    .o_b_pump  (O_PLL_B_PUMP_CURRENT)
  );

  assign O_PLL_A_REFERENCE_DIVIDER  = r_a_ref;
  assign O_PLL_A_FEEDBACK_PREDIVIDE = r_a_loop[`PCRS_A_PREDIV_BIT];
  assign O_PLL_A_INPUT_SELECT       = r_a_loop[`PCRS_A_SEL_BIT];
  assign O_PLL_B_REFERENCE_DIVIDER  = r_b_ref;
  assign O_PLL_B_FEEDBACK_DIVIDER   = fb_b_if.applied;
  assign O_SPREAD_RATE_PARAM        = rate_if.applied;
  assign O_SPREAD_COUNT_PARAM       = cnt_if.applied;
  assign O_SPREAD_STEP_PARAM        = step_if.applied;
  assign O_PLL_B_INPUT_SELECT       = r_b_loop[`PCRS_B_SEL_BIT];
  assign O_PLL_B_SPREAD_ENABLE      = r_b_spr_en[`PCRS_SPR_EN_BIT];
  assign O_PLL_C_REFERENCE_DIVIDER  = r_c_ref;
  assign O_PLL_C_FEEDBACK_DIVIDER   = fb_c_if.applied;

  default clocking cb_top @(posedge I_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_at(logic [7:0] a);
    I_WE && (I_ADDR == a);
  endsequence

  sequence s_rd_at(logic [7:0] a);
    I_RE && (I_ADDR == a);
  endsequence

  property p_a_ref;
    s_wr_at(`PCRS_ADDR_A_REF) |=> O_PLL_A_REFERENCE_DIVIDER == $past(I_WDATA);
  endproperty
  a_a_ref: assert property (p_a_ref)
    else $error("first loop reference divider not loaded");

  property p_a_select;
    s_wr_at(`PCRS_ADDR_A_LOOP) |=> O_PLL_A_INPUT_SELECT == $past(I_WDATA[`PCRS_A_SEL_BIT]);
  endproperty
  a_a_select: assert property (p_a_select)
    else $error("first loop input select not from bit 0");

  property p_b_ref;
    s_wr_at(`PCRS_ADDR_B_REF) |=> O_PLL_B_REFERENCE_DIVIDER == $past(I_WDATA);
  endproperty
  a_b_ref: assert property (p_b_ref)
    else $error("second loop reference divider not loaded");

  property p_b_fb_hold;
    s_wr_at(`PCRS_ADDR_B_FB_HI) |=> $stable(O_PLL_B_FEEDBACK_DIVIDER);
  endproperty
  a_b_fb_hold: assert property (p_b_fb_hold)
    else $error("second loop feedback moved on high byte alone");

  property p_b_fb_pair;
    s_wr_at(`PCRS_ADDR_B_FB_HI) ##1 s_wr_at(`PCRS_ADDR_B_SPR0) |=>
      O_PLL_B_FEEDBACK_DIVIDER == {$past(I_WDATA, 2), $past(I_WDATA[2:0])};
  endproperty
  a_b_fb_pair: assert property (p_b_fb_pair)
    else $error("second loop feedback not assembled from both bytes");

  property p_step_high;
    s_wr_at(`PCRS_ADDR_B_STEP_HI) |=> O_SPREAD_STEP_PARAM[12:5] == $past(I_WDATA);
  endproperty
  a_step_high: assert property (p_step_high)
    else $error("spread step high bits wrong");

  property p_b_select;
    s_wr_at(`PCRS_ADDR_B_LOOP) |=> O_PLL_B_INPUT_SELECT == $past(I_WDATA[`PCRS_B_SEL_BIT]);
  endproperty
  a_b_select: assert property (p_b_select)
    else $error("second loop input select wrong");

  property p_c_ref;
    s_wr_at(`PCRS_ADDR_C_REF) |=> O_PLL_C_REFERENCE_DIVIDER == $past(I_WDATA);
  endproperty
  a_c_ref: assert property (p_c_ref)
    else $error("third loop reference divider not loaded");

  property p_c_fb_pair;
    s_wr_at(`PCRS_ADDR_C_FB_HI) ##1 s_wr_at(`PCRS_ADDR_C_FB_LO) |=>
      O_PLL_C_FEEDBACK_DIVIDER == {$past(I_WDATA, 2), $past(I_WDATA[2:0])};
  endproperty
  a_c_fb_pair: assert property (p_c_fb_pair)
    else $error("third loop feedback not assembled from both bytes");

  property p_a_predivide;
    s_wr_at(`PCRS_ADDR_A_LOOP) |=>
      O_PLL_A_FEEDBACK_PREDIVIDE == $past(I_WDATA[`PCRS_A_PREDIV_BIT]);
  endproperty
  a_a_predivide: assert property (p_a_predivide)
    else $error("first loop predivide bit not taken from its field");

  // Reads under the window must not alias into the register array
  property p_below_window;
    I_RE && (I_ADDR < `PCRS_ADDR_FIRST) |=> O_RDATA == 8'h00;
  endproperty
  a_below_window: assert property (p_below_window)
    else $error("read below window not zero");

  property p_rsv_zero;
    s_rd_at(`PCRS_ADDR_A_LOOP) |=> O_RDATA[7] == 1'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bit reads nonzero");

  property p_unmapped;
    I_RE && (I_ADDR > `PCRS_ADDR_LAST) |=> O_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("read outside window not zero");

endmodule

// file: pcrs_host.sv
`timescale 1ns/100ps
module pcrs_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_we,
  output logic            o_re
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_we = 1'b0;
    o_re = 1'b0;
  end

  // Idle lines flip so no stale value looks like a live request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_we = 1'b1;
    @(negedge i_clk);
    o_we = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  // Two writes on consecutive edges, strobe held high across both
  task automatic wr2(input logic [7:0] a0, input logic [7:0] d0,
                     input logic [7:0] a1, input logic [7:0] d1);
    @(negedge i_clk);
    o_addr = a0;
    o_wdata = d0;
    o_we = 1'b1;
    @(negedge i_clk);
    o_addr = a1;
    o_wdata = d1;
    @(negedge i_clk);
    o_we = 1'b0;
    o_addr = ~a1;
    o_wdata = ~d1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_re = 1'b1;
    @(negedge i_clk);
    o_re = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule

// file: test_pll_config_register_slice.sv
`timescale 1ns/100ps
module test_pll_config_register_slice;
  logic        clk, nrst, we, re, a_pdv, a_sel, b_sel, b_sen;
  logic [7:0]  addr, wdata, rdata, a_ref, a_pump, b_ref, c_ref, d;
  logic [2:0]  a_rat;
  logic [6:0]  a_kohm, b_kohm;
  logic [10:0] b_fb, s_cnt, c_fb;
  logic [12:0] s_rate, s_step;
  logic [11:0] b_pump;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;
  int          kohm_tbl[4] = '{5, 10, 30, 80};
  int          a_pump_tbl[4] = '{63, 119, 177, 227};
  int          b_pump_tbl[8] = '{37, 110, 180, 340, 630, 1190, 1770, 2270};

  pcrs_host h (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_we(we), .o_re(re));

  pcrs_top u_dut (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WE(we), .I_RE(re), .O_RDATA(rdata), .O_PLL_A_REFERENCE_DIVIDER(a_ref),
    .O_PLL_A_FEEDBACK_PREDIVIDE(a_pdv), .O_PLL_A_PREDIVIDE_RATIO(a_rat),
    .O_PLL_A_ZERO_RESISTOR_KOHM(a_kohm), .O_PLL_A_PUMP_CURRENT(a_pump),
    .O_PLL_A_INPUT_SELECT(a_sel), .O_PLL_B_REFERENCE_DIVIDER(b_ref),
    .O_PLL_B_FEEDBACK_DIVIDER(b_fb), .O_SPREAD_RATE_PARAM(s_rate),
    .O_SPREAD_COUNT_PARAM(s_cnt), .O_SPREAD_STEP_PARAM(s_step),
    .O_PLL_B_ZERO_RESISTOR_KOHM(b_kohm), .O_PLL_B_PUMP_CURRENT(b_pump),
    .O_PLL_B_INPUT_SELECT(b_sel), .O_PLL_B_SPREAD_ENABLE(b_sen),
    .O_PLL_C_REFERENCE_DIVIDER(c_ref), .O_PLL_C_FEEDBACK_DIVIDER(c_fb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      close_out;
    end
  end

  task automatic t_reset;
    h.rd(8'h19, d);
    chk(16'(d), 16'h0040);
    h.rd(8'h11, d);
    chk(16'(d), 16'h0000);
    chk(16'(b_pump), 16'h0276);
    chk(16'(a_rat), 16'h0001);
    chk(16'(b_kohm), 16'h0005);
  endtask

  task automatic t_masks;
    // Last two sit just outside the window on either side
    logic [7:0] ad[8] = '{8'h11, 8'h19, 8'h1a, 8'h1d, 8'h0f, 8'h10, 8'h1e, 8'h0d};
    logic [7:0] ex[8] = '{8'h7f, 8'h77, 8'h08, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      h.wr(ad[i], 8'hff);
      h.rd(ad[i], d);
      chk(16'(d), 16'(ex[i]));
    end
    chk(16'(b_sen), 16'h0001);
    h.wr(8'h1a, 8'h00);
    chk(16'(b_sen), 16'h0000);
  endtask

  task automatic t_a_loop;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      h.wr(8'h11, {1'b0, k[0], k[1:0], k, k[1]});
      repeat (2) @(negedge clk);
      chk(16'(a_pdv), 16'(k[0]));
      chk(16'(a_rat), k[0] ? 16'h0004 : 16'h0001);
      chk(16'(a_kohm), 16'(kohm_tbl[k[1:0]]));
      chk(16'(a_pump), k[2] ? 16'(a_pump_tbl[k[1:0]]) : 16'h0000);
      chk(16'(a_sel), 16'(k[1]));
    end
  endtask

  task automatic t_b_loop;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      h.wr(8'h19, {1'b0, k, 1'b0, k[0], k[1:0]});
      repeat (2) @(negedge clk);
      chk(16'(b_pump), 16'(b_pump_tbl[i]));
      chk(16'(b_kohm), k[1:0] == 2'b11 ? 16'h0000 : 16'(kohm_tbl[k[1:0]]));
      chk(16'(b_sel), 16'(k[0]));
    end
  endtask

  task automatic t_div;
    h.wr(8'h0e, 8'ha5);
    h.wr(8'h12, 8'h3c);
    h.wr(8'h1b, 8'hc3);
    chk(16'(a_ref), 16'h00a5);
    chk(16'(b_ref), 16'h003c);
    chk(16'(c_ref), 16'h00c3);
  endtask

  task automatic t_split;
    h.wr(8'h13, 8'hab);
    @(negedge clk);
    chk(16'(b_fb), 16'h0000);
    h.wr(8'h14, 8'h5e);
    @(negedge clk);
    chk(16'(b_fb), 16'h055e);
    h.wr(8'h15, 8'h12);
    h.wr(8'h16, 8'h34);
    h.wr(8'h17, 8'had);
    @(negedge clk);
    chk(16'(s_rate), 16'h0000);
    h.wr(8'h18, 8'h56);
    @(negedge clk);
    chk(16'(s_rate), 16'h024b);
    chk(16'(s_cnt), 16'h01a5);
    chk(16'(s_step), 16'h0ad5);
    h.wr(8'h1c, 8'h9a);
    @(negedge clk);
    chk(16'(c_fb), 16'h0007);
    h.wr(8'h1d, 8'hfd);
    @(negedge clk);
    chk(16'(c_fb), 16'h04d5);
    // Back to back high and low bytes, no idle cycle between
    h.wr2(8'h13, 8'h3c, 8'h14, 8'h01);
    chk(16'(b_fb), 16'h01e1);
    h.wr2(8'h1c, 8'h0f, 8'h1d, 8'h02);
    chk(16'(c_fb), 16'h007a);
  endtask

  initial begin
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_masks;
    t_a_loop;
    t_b_loop;
    t_div;
    t_split;
    close_out;
  end
endmodule
